// File: design/frs_pkg.sv
// Purpose: Constants and types for the loop range and mode select block
// Assumes: AXI4-Lite register access, 32-bit data, 8-bit byte addresses
// Notes:   Mode codes are one-hot
`default_nettype none
package frs_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] OFS_RANGE_CTRL = 8'h00;
    localparam logic [7:0] OFS_TEST       = 8'h04;
    localparam logic [7:0] OFS_MODE_CTRL  = 8'h08;
    localparam logic [7:0] OFS_STATUS     = 8'h0c;
    // ==========================================================
    // Field positions and reset values
    localparam int RC_MAXTUNE   = 5;
    localparam int MC_IREF      = 0;
    localparam int MC_OCS_LSB   = 1;
    localparam int MC_LOOP      = 3;
    localparam int MC_LOWPWR    = 4;
    localparam int MC_REFERENCE_DIVIDER_LSB  = 5;
    localparam int MC_FRANGE    = 8;
    localparam int MC_REF_ENABLE_A     = 9;
    localparam int ST_MODE_LSB  = 16;
    localparam logic [7:0] RC_RESET   = 8'h00;
    localparam logic [7:0] TEST_RESET = 8'h00;
    localparam logic [9:0] MC_RESET   = 10'h001;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // Loop multiplication factors
    localparam logic [10:0] MULT_LO    = 11'h200;
    localparam logic [10:0] MULT_MID   = 11'h400;
    localparam logic [10:0] MULT_HI    = 11'h600;
    localparam logic [10:0] MULT_LO_X  = 11'h260;
    localparam logic [10:0] MULT_MID_X = 11'h4c0;
    localparam logic [10:0] MULT_HI_X  = 11'h720;
    // ==========================================================
    // Types
    typedef enum logic [5:0] {
        ENG_INT = 6'h01,
        ENG_EXT = 6'h02,
        BYP_INT = 6'h04,
        BYP_EXT = 6'h08,
        PLL_SEL = 6'h10,
        LOWPWR  = 6'h20
    } frs_mode_e;
    typedef enum logic [1:0] {
        SRC_FLL    = 2'h0,
        SRC_INTREF = 2'h1,
        SRC_EXTREF = 2'h2,
        SRC_PLL    = 2'h3
    } frs_src_e;
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } frs_axi_req_s;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } frs_axi_rsp_s;
    typedef struct packed {
        frs_src_e    mainSrc;
        logic        fllEnable;
        logic        pllEnable;
        logic        debugClkFromFll;
        logic        fllRefExt;
        logic [2:0]  refDivider;
        logic        refDiv32;
        logic [10:0] fllMult;
        frs_mode_e   mode;
    } frs_clk_ctl_s;
endpackage : frs_pkg
`default_nettype wire

// File: design/frs_fll_range_mode.sv
// Purpose: Loop range select, range status and loop mode control
// Assumes: Single clock; oscillator range copy crosses a sync chain
// Notes on behaviour
// - Max-tune bit narrows range for 32.768 kHz
// - Range status shows running oscillator range
// - Status updates only after synchronisation, not immediately
// - Status reads zero in PLL or low-power modes
// - Range select: low, mid, high, reserved
// - Range writes ignored while low-power or loop-select
// - Untuned factors 512, 1024, 1536
// - Tuned factors 608, 1216, 1824
// - Only permitted mode transitions are taken
// - Engaged internal: output from loop, internal reference
// - Engaged external: output from loop, external reference
// - Bypassed internal: output follows internal reference
// - Bypassed external: output follows external reference
// - Loop modes: debug clock from loop, PLL off
// - External reference divide set by divider fields
// - Divide-by-32 only with range bit; locked by loop-select
// - Loop-select picks PLL or loop, disables other
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`default_nettype none
module frs_fll_range_mode #(
    parameter int SYNC_STAGES = 2
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 debugMode,
    input  wire frs_pkg::frs_axi_req_s axiReq,
    output var  frs_pkg::frs_axi_rsp_s axiRsp,
    output var  frs_pkg::frs_clk_ctl_s clkCtl
);
    import frs_pkg::*;
    default clocking cbMain @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    if (SYNC_STAGES < 2) begin : g_stagesCheck
        $error("SYNC_STAGES must be at least 2");
    end

    // ==========================================================
    // Functions
    function automatic logic [10:0] multOf(input logic [1:0] sel,
                                           input logic tune);
        unique case (sel)
            2'h0:    multOf = tune ? MULT_LO_X  : MULT_LO;
            2'h1:    multOf = tune ? MULT_MID_X : MULT_MID;
            default: multOf = tune ? MULT_HI_X  : MULT_HI;
        endcase
    endfunction : multOf

    function automatic logic permitted(input frs_mode_e a,
                                       input frs_mode_e b);
        unique case (a)
            ENG_INT: permitted = b inside {ENG_EXT, BYP_INT};
            ENG_EXT: permitted = b inside {ENG_INT, BYP_EXT};
            BYP_INT: permitted = b inside {ENG_INT, BYP_EXT, LOWPWR};
            BYP_EXT: permitted = b inside {ENG_EXT, BYP_INT, LOWPWR,
                                           PLL_SEL};
            PLL_SEL: permitted = b inside {BYP_EXT, LOWPWR};
            LOWPWR:  permitted = b inside {BYP_INT, BYP_EXT, PLL_SEL};
            default: permitted = 1'b0;
        endcase
    endfunction : permitted

    // ==========================================================
    // Registers
    logic [1:0]  rangeSel;
    logic        maxTune;
    logic [4:0]  testBits;
    logic [7:0]  testReg;
    logic        internalRefSel;
    logic [1:0]  outClkSel;
    logic        loopSel;
    logic        lowPwrBypass;
    logic [2:0]  refDivider;
    logic        freqRange;
    logic        div32En;
    frs_mode_e   mode;
    frs_mode_e   reqMode;
    logic [1:0]  oscRange;
    logic [1:0]  rangeSync [SYNC_STAGES];
    logic [1:0]  rangeStatus;

    // ==========================================================
    // AXI4-Lite slave
    logic        awready, wready, bvalid, arready, rvalid;
    logic        awHeld, wHeld;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        takeAw, takeW, takeAr, doWrite;
    logic        next_awHeld, next_wHeld, next_bvalid;
    logic        wrCtrl, wrTest, wrMode, wrMapped;
    logic [31:0] rdMux;
    logic        rdMapped;

    assign takeAw      = axiReq.awvalid & awready;
    assign takeW       = axiReq.wvalid & wready;
    assign takeAr      = axiReq.arvalid & arready;
    assign doWrite     = awHeld & wHeld & ~bvalid;
    assign next_awHeld = (awHeld | takeAw) & ~doWrite;
    assign next_wHeld  = (wHeld | takeW) & ~doWrite;
    assign next_bvalid = doWrite | (bvalid & ~axiReq.bready);
    assign wrCtrl = doWrite & (awAddr[7:2] == OFS_RANGE_CTRL[7:2])
                    & wStrb[0];
    assign wrTest = doWrite & (awAddr[7:2] == OFS_TEST[7:2]) & wStrb[0];
    assign wrMode = doWrite & (awAddr[7:2] == OFS_MODE_CTRL[7:2]);
    assign wrMapped = awAddr[7:2] inside {OFS_RANGE_CTRL[7:2],
        OFS_TEST[7:2], OFS_MODE_CTRL[7:2], OFS_STATUS[7:2]};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            awHeld  <= 1'b0;
            wHeld   <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
        end else begin
            awHeld  <= next_awHeld;
            wHeld   <= next_wHeld;
            awready <= ~next_awHeld & ~next_bvalid;
            wready  <= ~next_wHeld & ~next_bvalid;
            bvalid  <= next_bvalid;
            if (doWrite) begin
                bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            awAddr <= 8'h00;
            wData  <= 32'h0000_0000;
            wStrb  <= 4'h0;
        end else begin
            if (takeAw) begin
                awAddr <= axiReq.awaddr;
            end
            if (takeW) begin
                wData <= axiReq.wdata;
                wStrb <= axiReq.wstrb;
            end
        end
    end

    always_comb begin
        rdMux    = 32'h0000_0000;
        rdMapped = 1'b1;
        unique case (axiReq.araddr[7:2])
            OFS_RANGE_CTRL[7:2]: rdMux[7:0] = {testBits[4:3], maxTune,
                                  testBits[2:0], rangeStatus};
            OFS_TEST[7:2]:       rdMux[7:0] = testReg;
            OFS_MODE_CTRL[7:2]:  rdMux[9:0] = {div32En, freqRange,
                                  refDivider, lowPwrBypass, loopSel,
                                  outClkSel, internalRefSel};
            OFS_STATUS[7:2]:     rdMux = {10'h000, mode, 5'h00,
                                  clkCtl.fllMult};
            default:             rdMapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else if (takeAr) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rdMux;
            rresp   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid & axiReq.rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

    assign axiRsp = '{awready: awready, wready: wready, bvalid: bvalid,
                      bresp: bresp, arready: arready, rvalid: rvalid,
                      rdata: rdata, rresp: rresp};

    // ==========================================================
    // Control registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rangeSel <= RC_RESET[1:0];
            maxTune  <= RC_RESET[RC_MAXTUNE];
            testBits <= {RC_RESET[7:6], RC_RESET[4:2]};
            testReg  <= TEST_RESET;
        end else begin
            if (wrCtrl) begin
                maxTune  <= wData[RC_MAXTUNE];
                testBits <= {wData[7:6], wData[4:2]};
                if (!(lowPwrBypass | loopSel)) begin
                    rangeSel <= wData[1:0];
                end
            end
            if (wrTest) begin
                testReg <= wData[7:0];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {div32En, freqRange, refDivider, lowPwrBypass, loopSel,
             outClkSel, internalRefSel} <= MC_RESET;
        end else if (wrMode) begin
            if (wStrb[0]) begin
                internalRefSel <= wData[MC_IREF];
                outClkSel      <= wData[MC_OCS_LSB +: 2];
                loopSel        <= wData[MC_LOOP];
                lowPwrBypass   <= wData[MC_LOWPWR];
                refDivider     <= wData[MC_REFERENCE_DIVIDER_LSB +: 3];
            end
            if (wStrb[1]) begin
                freqRange <= wData[MC_FRANGE];
                if (!loopSel) begin
                    div32En <= wData[MC_REF_ENABLE_A];
                end
            end
        end
    end

    // ==========================================================
    // Mode sequencing
    always_comb begin
        reqMode = mode;
        if (outClkSel != 2'h0 && lowPwrBypass && !debugMode) begin
            reqMode = LOWPWR;
        end else if (loopSel) begin
            reqMode = PLL_SEL;
        end else if (outClkSel == 2'h0) begin
            reqMode = internalRefSel ? ENG_INT : ENG_EXT;
        end else if (outClkSel == 2'h1 && internalRefSel) begin
            reqMode = BYP_INT;
        end else if (outClkSel == 2'h2 && !internalRefSel) begin
            reqMode = BYP_EXT;
        end
    end

    // Illegal requests simply hold the present mode
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode <= ENG_INT;
        end else if (permitted(mode, reqMode)) begin
            mode <= reqMode;
        end
    end

    // ==========================================================
    // Oscillator range and status synchroniser
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oscRange <= RC_RESET[1:0];
            for (int i = 0; i < SYNC_STAGES; i++) begin
                rangeSync[i] <= 2'h0;
            end
        end else begin
            oscRange     <= rangeSel;
            rangeSync[0] <= oscRange;
            for (int i = 1; i < SYNC_STAGES; i++) begin
                rangeSync[i] <= rangeSync[i-1];
            end
        end
    end

    // Status is meaningless with the loop stopped
    assign rangeStatus = (mode inside {PLL_SEL, LOWPWR}) ? 2'h0
                         : rangeSync[SYNC_STAGES-1];

    // ==========================================================
    // Clock steering outputs
    logic fllMode;
    assign fllMode = mode inside {ENG_INT, ENG_EXT, BYP_INT, BYP_EXT};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clkCtl <= '{mainSrc: SRC_FLL, fllEnable: 1'b1,
                        pllEnable: 1'b0, debugClkFromFll: 1'b1,
                        fllRefExt: 1'b0, refDivider: 3'h0,
                        refDiv32: 1'b0, fllMult: MULT_LO, mode: ENG_INT};
        end else begin
            unique case (mode)
                ENG_INT, ENG_EXT: clkCtl.mainSrc <= SRC_FLL;
                BYP_INT:          clkCtl.mainSrc <= SRC_INTREF;
                BYP_EXT:          clkCtl.mainSrc <= SRC_EXTREF;
                PLL_SEL:          clkCtl.mainSrc <=
                    (outClkSel == 2'h0) ? SRC_PLL : SRC_EXTREF;
                default:          clkCtl.mainSrc <=
                    internalRefSel ? SRC_INTREF : SRC_EXTREF;
            endcase
            clkCtl.fllEnable       <= ~loopSel & fllMode;
            clkCtl.pllEnable       <= loopSel & ~fllMode;
            clkCtl.debugClkFromFll <= fllMode;
            clkCtl.fllRefExt       <= fllMode
                ? (mode inside {ENG_EXT, BYP_EXT}) : ~internalRefSel;
            clkCtl.refDivider      <= refDivider;
            clkCtl.refDiv32        <= freqRange & div32En;
            clkCtl.fllMult         <= multOf(oscRange, maxTune);
            clkCtl.mode            <= mode;
        end
    end

    // ==========================================================
    // Checks
    sequence s_ctrlWrite;
        wrCtrl;
    endsequence
    // Only a quiet chain shows the lag; back-to-back writes overlap
    sequence s_rangeSettled;
        rangeSel == oscRange && oscRange == rangeSync[0]
        && rangeSync[0] == rangeSync[SYNC_STAGES-1];
    endsequence
    property p_statusLags;
        s_ctrlWrite and s_rangeSettled
        |=> $stable(rangeSync[SYNC_STAGES-1]) [*2];
    endproperty
    a_statusLags: assert property (p_statusLags)
        else $error("Range status changed too early");
    property p_statusZero;
        takeAr && axiReq.araddr[7:2] == OFS_RANGE_CTRL[7:2]
        && mode inside {PLL_SEL, LOWPWR} |=> rdata[1:0] == 2'h0;
    endproperty
    a_statusZero: assert property (p_statusZero)
        else $error("Range status not zero");
    property p_rangeLocked;
        s_ctrlWrite and (loopSel || lowPwrBypass) |=> $stable(rangeSel);
    endproperty
    a_rangeLocked: assert property (p_rangeLocked)
        else $error("Range write not ignored");
    property p_div32Locked;
        wrMode && loopSel |=> $stable(div32En);
    endproperty
    a_div32Locked: assert property (p_div32Locked)
        else $error("Divide-by-32 write not ignored");
    property p_untunedHigh;
        wrCtrl && !loopSel && !lowPwrBypass && wData[5:0] == 6'h02
        |-> ##3 clkCtl.fllMult == 11'd1536;
    endproperty
    a_untunedHigh: assert property (p_untunedHigh)
        else $error("Untuned high factor wrong");
    property p_tunedMid;
        wrCtrl && !loopSel && !lowPwrBypass && wData[5:0] == 6'h21
        |-> ##3 clkCtl.fllMult == 11'd1216;
    endproperty
    a_tunedMid: assert property (p_tunedMid)
        else $error("Tuned mid factor wrong");
    property p_legalStep;
        mode != $past(mode) |-> permitted($past(mode), mode);
    endproperty
    a_legalStep: assert property (p_legalStep)
        else $error("Illegal mode transition");
    property p_loopExclusive;
        loopSel |=> !clkCtl.fllEnable;
    endproperty
    a_loopExclusive: assert property (p_loopExclusive)
        else $error("Loop still enabled with PLL selected");
    property p_fllModes;
        fllMode |=> clkCtl.debugClkFromFll && !clkCtl.pllEnable;
    endproperty
    a_fllModes: assert property (p_fllModes)
        else $error("Loop mode clock steering wrong");
    property p_engagedInt;
        mode == ENG_INT |=> clkCtl.mainSrc == SRC_FLL
                            && !clkCtl.fllRefExt;
    endproperty
    a_engagedInt: assert property (p_engagedInt)
        else $error("Engaged internal source wrong");
endmodule : frs_fll_range_mode
`default_nettype wire

// File: testbench/tb_fll_range_and_mode_select.sv
// Purpose: Self-checking bench for loop range and mode select
// Assumes: bready and rready held high, one write and one read at a time
// Notes:   Driver queues expectations, monitor compares on each answer
`default_nettype none
module tb_fll_range_and_mode_select;
    timeunit 1ns;
    timeprecision 1ps;
    import frs_pkg::*;
    // ==========================================================
    // Signals
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic [1:0]  resp;
    } frs_tb_note_s;
    logic         clk;
    logic         sysRst;
    logic         debugMode;
    frs_axi_req_s axiReq;
    frs_axi_rsp_s axiRsp;
    frs_clk_ctl_s clkCtl;
    frs_tb_note_s readQ[$];
    logic [1:0]   writeQ[$];
    int           n_mismatch;
    int           samples_checked;
    logic [15:0]  lfsrState;
    frs_fll_range_mode #(.SYNC_STAGES(2)) dut (
        .clk(clk), .sys_rst(sysRst), .debugMode(debugMode),
        .axiReq(axiReq), .axiRsp(axiRsp), .clkCtl(clkCtl));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ==========================================================
    // Helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic summarize();
        $display("Mismatches %0d, comparisons %0d", n_mismatch,
                 samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask : check
    task automatic timed_out(input string what);
        $display("ERROR %s expected answer seen timeout", what);
        n_mismatch++;
        summarize();
    endtask : timed_out
    task automatic idle(input int cycles);
        repeat (cycles) @(posedge clk);
    endtask : idle
    // ==========================================================
    // Bus master, valid held until its own ready
    task automatic axi_wr(input logic [7:0] addr, input logic [31:0] data,
                          input logic [1:0] resp);
        logic awOpen;
        logic wOpen;
        int   n;
        awOpen = 1'b1;
        wOpen  = 1'b1;
        writeQ.push_back(resp);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr  <= addr;
        axiReq.wvalid  <= 1'b1;
        axiReq.wdata   <= data;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (awOpen && axiRsp.awready) begin
                awOpen = 1'b0;
                axiReq.awvalid <= 1'b0;
            end
            if (wOpen && axiRsp.wready) begin
                wOpen = 1'b0;
                axiReq.wvalid <= 1'b0;
            end
            if (axiRsp.bvalid) break;
        end
        if (n == 64) timed_out("bvalid");
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] addr, input logic [31:0] data,
                          input logic [31:0] mask, input logic [1:0] resp);
        int n;
        readQ.push_back('{data, mask, resp});
        axiReq.arvalid <= 1'b1;
        axiReq.araddr  <= addr;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (axiRsp.arready) axiReq.arvalid <= 1'b0;
            if (axiRsp.rvalid) break;
        end
        if (n == 64) timed_out("rvalid");
    endtask : axi_rd
    // ==========================================================
    // Monitor, oldest note against each answer
    always @(posedge clk) begin : monitor
        frs_tb_note_s note;
        if (axiRsp.rvalid && axiReq.rready && readQ.size() > 0) begin
            note = readQ.pop_front();
            check("rdata", note.data & note.mask, axiRsp.rdata & note.mask);
            check("rresp", {30'h0, note.resp}, {30'h0, axiRsp.rresp});
        end
        if (axiRsp.bvalid && axiReq.bready && writeQ.size() > 0) begin
            check("bresp", {30'h0, writeQ.pop_front()}, {30'h0, axiRsp.bresp});
        end
    end
    // ==========================================================
    // Scenario steps
    task automatic set_range(input logic tune, input logic [1:0] sel,
                             input logic [10:0] mult);
        logic [31:0] v;
        v = {26'h0, tune, 3'h0, sel};
        axi_wr(OFS_RANGE_CTRL, v, RESP_OKAY);
        idle(4);
        axi_rd(OFS_RANGE_CTRL, v, 32'hff, RESP_OKAY);
        axi_rd(OFS_STATUS, {21'h0, mult}, 32'h7ff, RESP_OKAY);
        check("fllMult", {21'h0, mult}, {21'h0, clkCtl.fllMult});
    endtask : set_range
    task automatic set_mode(input logic [9:0] ctl, input frs_mode_e m);
        axi_wr(OFS_MODE_CTRL, {22'h0, ctl}, RESP_OKAY);
        axi_rd(OFS_STATUS, {10'h0, m, 16'h0}, 32'h003f0000, RESP_OKAY);
        check("mode", {26'h0, m}, {26'h0, clkCtl.mode});
    endtask : set_mode
    task automatic ctl_chk(input frs_src_e src, input logic [3:0] flags);
        check("clkCtl", {26'h0, src, flags}, {26'h0, clkCtl.mainSrc,
              clkCtl.fllEnable, clkCtl.pllEnable, clkCtl.debugClkFromFll,
              clkCtl.fllRefExt});
    endtask : ctl_chk
    // ==========================================================
    // Main sequence
    initial begin : main
        logic [10:0] mults [6];
        logic [31:0] v;
        int          i;
        mults = '{MULT_LO, MULT_MID, MULT_HI, MULT_LO_X, MULT_MID_X,
                  MULT_HI_X};
        n_mismatch = 0;
        samples_checked = 0;
        lfsrState = 16'h2171;
        sysRst = 1'b1;
        debugMode = 1'b0;
        axiReq = '0;
        axiReq.wstrb = 4'hf;
        axiReq.bready = 1'b1;
        axiReq.rready = 1'b1;
        repeat (20) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        axi_rd(OFS_RANGE_CTRL, {24'h0, RC_RESET}, 32'hff, RESP_OKAY);
        axi_rd(OFS_TEST, {24'h0, TEST_RESET}, 32'hff, RESP_OKAY);
        axi_rd(OFS_MODE_CTRL, {22'h0, MC_RESET}, 32'h3ff, RESP_OKAY);
        v = {10'h0, ENG_INT, 5'h0, MULT_LO};
        axi_rd(OFS_STATUS, v, 32'hffffffff, RESP_OKAY);
        ctl_chk(SRC_FLL, 4'b1010);
        // Test bits of range control always written as zero
        for (i = 0; i < 6; i++) begin
            set_range(i >= 3, 2'(i % 3), mults[i]);
        end
        set_range(1'b0, 2'h0, MULT_LO);
        fork
            axi_wr(OFS_RANGE_CTRL, 32'h1, RESP_OKAY);
            axi_rd(OFS_RANGE_CTRL, 32'h0, 32'h3, RESP_OKAY);
        join
        axi_rd(OFS_RANGE_CTRL, 32'h0, 32'h3, RESP_OKAY);
        idle(4);
        axi_rd(OFS_RANGE_CTRL, 32'h1, 32'h3, RESP_OKAY);
        // Reserved test bits kept clear in random data
        for (i = 0; i < 4; i++) begin
            lfsrState = lfsr_next(lfsrState);
            v = {24'h0, lfsrState[7:0] & 8'hde};
            axi_wr(OFS_TEST, v, RESP_OKAY);
            axi_rd(OFS_TEST, v, 32'hff, RESP_OKAY);
        end
        axi_wr(8'h10, 32'hffffffff, RESP_SLVERR);
        axi_rd(8'h10, 32'h0, 32'h0, RESP_SLVERR);
        set_mode(10'h003, BYP_INT);
        ctl_chk(SRC_INTREF, 4'b1010);
        debugMode <= 1'b1;
        set_mode(10'h013, BYP_INT);
        debugMode <= 1'b0;
        set_mode(10'h013, LOWPWR);
        axi_rd(OFS_RANGE_CTRL, 32'h0, 32'h3, RESP_OKAY);
        axi_wr(OFS_RANGE_CTRL, 32'h2, RESP_OKAY);
        set_mode(10'h003, BYP_INT);
        idle(4);
        axi_rd(OFS_STATUS, {21'h0, MULT_MID}, 32'h7ff, RESP_OKAY);
        set_mode(10'h004, BYP_EXT);
        ctl_chk(SRC_EXTREF, 4'b1011);
        set_mode(10'h000, ENG_EXT);
        ctl_chk(SRC_FLL, 4'b1011);
        set_mode(10'h003, ENG_EXT);
        set_mode(10'h1a0, ENG_EXT);
        check("refDivider", 32'h5, {29'h0, clkCtl.refDivider});
        check("refDiv32", 32'h0, {31'h0, clkCtl.refDiv32});
        set_mode(10'h3a0, ENG_EXT);
        check("refDiv32", 32'h1, {31'h0, clkCtl.refDiv32});
        set_mode(10'h200, ENG_EXT);
        check("refDiv32", 32'h0, {31'h0, clkCtl.refDiv32});
        set_mode(10'h004, BYP_EXT);
        set_mode(10'h00c, PLL_SEL);
        check("pllFll", 32'h2, {30'h0, clkCtl.pllEnable,
              clkCtl.fllEnable});
        ctl_chk(SRC_EXTREF, 4'b0101);
        axi_rd(OFS_RANGE_CTRL, 32'h0, 32'h3, RESP_OKAY);
        axi_wr(OFS_RANGE_CTRL, 32'h0, RESP_OKAY);
        set_mode(10'h30c, PLL_SEL);
        check("refDiv32", 32'h0, {31'h0, clkCtl.refDiv32});
        set_mode(10'h004, BYP_EXT);
        check("pllFll", 32'h2, {30'h0, clkCtl.fllEnable,
              clkCtl.pllEnable});
        set_mode(10'h000, ENG_EXT);
        set_mode(10'h001, ENG_INT);
        idle(4);
        axi_rd(OFS_STATUS, {21'h0, MULT_MID}, 32'h7ff, RESP_OKAY);
        summarize();
    end
    // Hang guard, well beyond the full sequence
    initial begin
        repeat (20000) @(posedge clk);
        timed_out("run");
    end
endmodule : tb_fll_range_and_mode_select
`default_nettype wire
